/* src/rasq_pkg.sv */
// constants, register map and state types of the reset and activation sequencer
package rasq_pkg;
    localparam int          CLK_HZ          = 200_000_000;
    localparam int          RTC_HZ          = 32_768;
    localparam int          PLL_SETTLE_MS   = 16;
    localparam int          PWR_SETTLE_MS   = 350;
    localparam int          COLD_HOLD_MS    = 2;
    localparam int          HALT_LIMIT_S    = 4;
    localparam int          PLL_SETTLE_CYC  = PLL_SETTLE_MS * (CLK_HZ / 1000);
    localparam int          PWR_SETTLE_CYC  = PWR_SETTLE_MS * (CLK_HZ / 1000);
    localparam int          COLD_HOLD_CYC   = COLD_HOLD_MS * (CLK_HZ / 1000);
    localparam int          HALT_LIMIT_TICK = HALT_LIMIT_S * RTC_HZ;
    localparam logic [1:0]  BATT_CHECK_TICK = 2'h3;
    localparam logic [1:0]  FAIL_HOLD_TICK  = 2'h1;
    localparam logic [1:0]  OK_HOLD_TICK    = 2'h3;
    // register byte offsets
    localparam logic [4:0]  OFS_CTRL        = 5'h00;
    localparam logic [4:0]  OFS_WDT_LIMIT   = 5'h04;
    localparam logic [4:0]  OFS_WDT_CLEAR   = 5'h08;
    localparam logic [4:0]  OFS_STATUS      = 5'h0C;
    // control bit positions
    localparam int          CTRL_WDT_EN     = 0;
    localparam int          CTRL_HALT_STOP  = 1;
    localparam int          CTRL_DRAM_KEEP  = 2;
    localparam logic [23:0] WDT_LIMIT_RST   = 24'h008000;
    // cold reset load values
    localparam logic [4:0]  RANDOM_INIT     = 5'h1F;
    localparam logic [4:0]  WIRED_INIT      = 5'h00;
    localparam logic [3:0]  CFG_HI_INIT     = 4'h0;
    localparam logic [19:0] CFG_MID_INIT    = 20'h04800;

    typedef enum logic [3:0] {
        ST_CAL, ST_OFF, ST_REQ, ST_FAIL, ST_OK, ST_MPWR,
        ST_PLL, ST_COLD, ST_GEN, ST_RUN, ST_SWHOLD
    } rasq_state_e;

    typedef enum logic [2:0] {
        CA_CAL, CA_SWITCH, CA_WDT, CA_SLEEP, CA_HALT, CA_BATT
    } rasq_cause_e;
endpackage

/* src/rasq_sequencer.sv */
// reset source merge, power-on activation handshake and core cold reset sequencing
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module rasq_sequencer import rasq_pkg::*; #(
    parameter int unsigned PLL_SETTLE_CYCLES = PLL_SETTLE_CYC,
    parameter int unsigned PWR_SETTLE_CYCLES = PWR_SETTLE_CYC,
    parameter int unsigned COLD_HOLD_CYCLES  = COLD_HOLD_CYC,
    parameter int unsigned HALT_LIMIT_TICKS  = HALT_LIMIT_TICK
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // register bus
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // asynchronous pins
    input  wire logic        rtc_clk_i,
    input  wire logic        clock_calendar_reset_n_i,
    input  wire logic        reset_switch_n_i,
    input  wire logic        power_button_i,
    input  wire logic        carrier_detect_n_i,
    input  wire logic [15:0] gpio_wake_i,
    input  wire logic        elapsed_alarm_i,
    input  wire logic        card_irq_i,
    input  wire logic        wakeup_alarm_timer_i,
    input  wire logic        wake_irq_i,
    input  wire logic        battery_inhibit_in_i,
    input  wire logic        battery_low_i,
    input  wire logic        battery_lock_release_i,
    // core side
    input  wire logic        deep_sleep_i,
    // power supply side
    output logic             power_request_out_o,
    output logic             main_power_enable_o,
    output logic             pll_enable_o,
    output logic             clocks_enable_o,
    output logic             dram_self_refresh_o,
    // reset outputs
    output logic             periph_reset_o,
    output logic             full_core_init_n_o,
    output logic             core_reset_n_o,
    output logic             bus_owner_o,
    output logic             reset_vector_fetch_o,
    // cold reset load values for the core
    output logic             tlb_shutdown_flag_o,
    output logic             soft_reset_flag_o,
    output logic             error_level_flag_o,
    output logic             bootstrap_vector_flag_o,
    output logic      [4:0]  random_index_o,
    output logic      [4:0]  wired_index_o,
    output logic      [31:0] config_init_o
);
    localparam int NPIN = 28;

    // pin synchronisers
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    logic            rtc_s3;
    logic [NPIN-1:0] pin_raw;
    logic            rtc_tick;
    logic            cal_rst_n, sw_n, pwr_btn, carrier_n, alarm_el, card_irq;
    logic            wake_alarm, wake_irq, batt_inh, batt_low, batt_lock;
    logic [15:0]     gpio_w;

    assign pin_raw = {rtc_clk_i, clock_calendar_reset_n_i, reset_switch_n_i, power_button_i,
                      carrier_detect_n_i, gpio_wake_i, elapsed_alarm_i, card_irq_i,
                      wakeup_alarm_timer_i, wake_irq_i, battery_inhibit_in_i,
                      battery_low_i, battery_lock_release_i};

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            rtc_s3 <= 1'b0;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            rtc_s3 <= pin_s2[NPIN-1];
        end
    end

    assign {cal_rst_n, sw_n, pwr_btn, carrier_n, gpio_w, alarm_el, card_irq,
            wake_alarm, wake_irq, batt_inh, batt_low, batt_lock} = pin_s2[NPIN-2:0];
    // one pulse per rising edge of the slow real-time clock
    assign rtc_tick = pin_s2[NPIN-1] & ~rtc_s3;

    // register bus
    logic        ctrl_wdt_en, ctrl_dram_keep, halt_armed;
    logic [23:0] wdt_limit;
    logic        wait_q, next_wait;
    logic [31:0] rdata_q, next_rdata;
    logic        wr_go, rd_hit;
    logic        next_wdt_en, next_dram_keep;
    logic [23:0] next_wdt_limit;
    logic        wdt_clear;

    // state
    rasq_state_e state, next_state;
    rasq_cause_e cause, next_cause;
    logic [31:0] cyc_cnt, next_cyc_cnt;
    logic [1:0]  tick_cnt, next_tick_cnt;
    logic [23:0] wdt_cnt, next_wdt_cnt;
    logic [17:0] halt_cnt, next_halt_cnt;
    logic        next_halt_armed;
    logic        keep_q, next_keep;
    logic        wdt_fire, halt_fire, wake_any, wake_ok;

    // a request is answered one cycle after it is first seen
    assign wr_go = avs_write_i & ~wait_q;
    assign rd_hit = avs_read_i & wait_q;
    assign wdt_clear = wr_go && (avs_address_i == OFS_WDT_CLEAR);

    always_comb begin
        next_wait      = 1'b1;
        next_rdata     = rdata_q;
        next_wdt_en    = ctrl_wdt_en;
        next_dram_keep = ctrl_dram_keep;
        next_wdt_limit = wdt_limit;
        if ((avs_read_i | avs_write_i) && wait_q) begin
            next_wait = 1'b0;
        end
        if (rd_hit) begin
            case (avs_address_i)
                OFS_CTRL:      next_rdata = {29'h0, ctrl_dram_keep, ~halt_armed, ctrl_wdt_en};
                OFS_WDT_LIMIT: next_rdata = {8'h00, wdt_limit};
                OFS_STATUS:    next_rdata = {16'h0, 1'b0, cause, 8'h00, 4'(state)};
                default:       next_rdata = 32'h0;
            endcase
        end
        if (wr_go && (avs_address_i == OFS_CTRL)) begin
            next_wdt_en    = avs_writedata_i[CTRL_WDT_EN];
            next_dram_keep = avs_writedata_i[CTRL_DRAM_KEEP];
        end
        if (wr_go && (avs_address_i == OFS_WDT_LIMIT)) begin
            next_wdt_limit = avs_writedata_i[23:0];
        end
        // the watchdog belongs to the reset domain, so any reset disables it
        if (state != ST_RUN) begin
            next_wdt_en = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wait_q         <= 1'b1;
            rdata_q        <= 32'h0;
            ctrl_wdt_en    <= 1'b0;
            ctrl_dram_keep <= 1'b0;
            wdt_limit      <= WDT_LIMIT_RST;
        end else begin
            wait_q         <= next_wait;
            rdata_q        <= next_rdata;
            ctrl_wdt_en    <= next_wdt_en;
            ctrl_dram_keep <= next_dram_keep;
            wdt_limit      <= next_wdt_limit;
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o    = rdata_q;

    // timers on the slow clock; the watchdog count clears whenever the watchdog is off, so outside ST_RUN; the halt count clears only in ST_CAL
    always_comb begin
        next_wdt_cnt    = wdt_cnt;
        next_halt_cnt   = halt_cnt;
        next_halt_armed = halt_armed;
        if (!ctrl_wdt_en || wdt_clear) begin
            next_wdt_cnt = 24'h0;
        end else if (rtc_tick && !wdt_fire) begin
            next_wdt_cnt = wdt_cnt + 24'h1;
        end
        if (state == ST_CAL) begin
            next_halt_armed = 1'b1;
            next_halt_cnt   = 18'h0;
        end else if (halt_armed && rtc_tick && !halt_fire) begin
            next_halt_cnt = halt_cnt + 18'h1;
        end
        if (wr_go && (avs_address_i == OFS_CTRL) && avs_writedata_i[CTRL_HALT_STOP]) begin
            next_halt_armed = 1'b0;
        end
        if (halt_fire && state == ST_RUN) begin
            next_halt_armed = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wdt_cnt    <= 24'h0;
            halt_cnt   <= 18'h0;
            halt_armed <= 1'b0;
        end else begin
            wdt_cnt    <= next_wdt_cnt;
            halt_cnt   <= next_halt_cnt;
            halt_armed <= next_halt_armed;
        end
    end

    assign wdt_fire  = ctrl_wdt_en && (wdt_cnt >= wdt_limit);
    assign halt_fire = halt_armed && (32'(halt_cnt) >= HALT_LIMIT_TICKS);

    assign wake_any = pwr_btn | ~carrier_n | (|gpio_w) | alarm_el | card_irq;
    always_comb begin
        case (cause)
            CA_SLEEP: wake_ok = pwr_btn | ~carrier_n | wake_irq;
            CA_HALT:  wake_ok = pwr_btn | wake_alarm;
            default:  wake_ok = wake_any;
        endcase
    end

    // one sequencer for every cause: each ends in the same cold reset path
    always_comb begin
        next_state    = state;
        next_cause    = cause;
        next_cyc_cnt  = cyc_cnt + 32'h1;
        next_tick_cnt = rtc_tick ? tick_cnt + 2'h1 : tick_cnt;
        next_keep     = keep_q;
        case (state)
            ST_CAL: begin
                if (cal_rst_n && rtc_tick) begin
                    next_state = ST_REQ;
                end
            end
            ST_OFF: begin
                if (wake_ok) begin
                    next_state = ST_REQ;
                end
            end
            ST_REQ: begin
                if (rtc_tick && tick_cnt == BATT_CHECK_TICK - 2'h1) begin
                    next_state = batt_inh ? ST_OK : ST_FAIL;
                end
            end
            ST_FAIL: begin
                if (rtc_tick && tick_cnt == FAIL_HOLD_TICK - 2'h1) begin
                    next_state = ST_OFF;
                end
            end
            ST_OK: begin
                if (rtc_tick && tick_cnt == OK_HOLD_TICK - 2'h1) begin
                    next_state = ST_MPWR;
                end
            end
            ST_MPWR: begin
                if (cyc_cnt == PWR_SETTLE_CYCLES - 1) begin
                    next_state = ST_PLL;
                end
            end
            ST_PLL: begin
                if (cyc_cnt == PLL_SETTLE_CYCLES - 1) begin
                    next_state = ST_COLD;
                end
            end
            ST_COLD: begin
                if (cyc_cnt == COLD_HOLD_CYCLES - 1) begin
                    next_state = ST_GEN;
                end
            end
            ST_GEN: begin
                next_state = ST_RUN;
                next_keep  = 1'b0;
            end
            ST_RUN: begin
                if (!sw_n) begin
                    next_state = ST_SWHOLD;
                    next_cause = CA_SWITCH;
                    next_keep  = ctrl_dram_keep;
                end else if (batt_low || batt_lock) begin
                    next_state = ST_OFF;
                    next_cause = CA_BATT;
                end else if (deep_sleep_i) begin
                    next_state = ST_OFF;
                    next_cause = CA_SLEEP;
                end else if (halt_fire) begin
                    next_state = ST_OFF;
                    next_cause = CA_HALT;
                end else if (wdt_fire) begin
                    next_state = ST_PLL;
                    next_cause = CA_WDT;
                    next_keep  = 1'b0;
                end
            end
            ST_SWHOLD: begin
                if (sw_n) begin
                    next_state = ST_PLL;
                end
            end
            default: begin
                next_state = ST_CAL;
            end
        endcase
        // the calendar reset overrides every other cause
        if (!cal_rst_n) begin
            next_state = ST_CAL;
            next_cause = CA_CAL;
            next_keep  = 1'b0;
        end
        if (next_state != state) begin
            next_cyc_cnt  = 32'h0;
            next_tick_cnt = 2'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state    <= ST_CAL;
            cause    <= CA_CAL;
            cyc_cnt  <= 32'h0;
            tick_cnt <= 2'h0;
            keep_q   <= 1'b0;
        end else begin
            state    <= next_state;
            cause    <= next_cause;
            cyc_cnt  <= next_cyc_cnt;
            tick_cnt <= next_tick_cnt;
            keep_q   <= next_keep;
        end
    end

    // outputs decoded from the next state so they change with it
    logic next_preq, next_mpwr, next_pll, next_clk, next_cold_n, next_rst_n, next_fetch;

    always_comb begin
        next_preq   = (next_state == ST_REQ) || (next_state == ST_FAIL) ||
                      (next_state == ST_OK);
        // main power drops in the same edge that enters shutdown
        next_mpwr   = (next_state == ST_OK) || (next_state == ST_MPWR) ||
                      (next_state == ST_PLL) || (next_state == ST_COLD) ||
                      (next_state == ST_GEN) || (next_state == ST_RUN) ||
                      (next_state == ST_SWHOLD);
        next_pll    = (next_state == ST_PLL) || (next_state == ST_COLD) ||
                      (next_state == ST_GEN) || (next_state == ST_RUN);
        next_clk    = (next_state == ST_COLD) || (next_state == ST_GEN) ||
                      (next_state == ST_RUN);
        next_cold_n = (next_state == ST_GEN) || (next_state == ST_RUN);
        next_rst_n  = (next_state == ST_RUN);
        next_fetch  = (next_state == ST_RUN) && (state == ST_GEN);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            power_request_out_o  <= 1'b0;
            main_power_enable_o  <= 1'b0;
            pll_enable_o         <= 1'b0;
            clocks_enable_o      <= 1'b0;
            dram_self_refresh_o  <= 1'b0;
            periph_reset_o       <= 1'b1;
            full_core_init_n_o   <= 1'b0;
            core_reset_n_o       <= 1'b0;
            bus_owner_o          <= 1'b0;
            reset_vector_fetch_o <= 1'b0;
        end else begin
            power_request_out_o  <= next_preq;
            main_power_enable_o  <= next_mpwr;
            pll_enable_o         <= next_pll;
            clocks_enable_o      <= next_clk;
            dram_self_refresh_o  <= next_keep;
            periph_reset_o       <= ~next_rst_n;
            full_core_init_n_o   <= next_cold_n;
            core_reset_n_o       <= next_rst_n;
            bus_owner_o          <= next_rst_n;
            reset_vector_fetch_o <= next_fetch;
        end
    end

    // values the core takes while its cold reset is held; undefined config bits read zero
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tlb_shutdown_flag_o     <= 1'b0;
            soft_reset_flag_o       <= 1'b0;
            error_level_flag_o      <= 1'b1;
            bootstrap_vector_flag_o <= 1'b1;
            random_index_o          <= RANDOM_INIT;
            wired_index_o           <= WIRED_INIT;
            config_init_o           <= {CFG_HI_INIT, 5'h00, CFG_MID_INIT, 3'h0};
        end else if (!next_cold_n) begin
            tlb_shutdown_flag_o     <= 1'b0;
            soft_reset_flag_o       <= 1'b0;
            error_level_flag_o      <= 1'b1;
            bootstrap_vector_flag_o <= 1'b1;
            random_index_o          <= RANDOM_INIT;
            wired_index_o           <= WIRED_INIT;
            config_init_o           <= {CFG_HI_INIT, 5'h00, CFG_MID_INIT, 3'h0};
        end
    end
endmodule

/* verif/rasq_props.sv */
// concurrent checks on the reset and activation sequencer ports
`timescale 1ns/1ps
module rasq_props #(
    parameter int unsigned PLL_SETTLE_CYCLES = 20,
    parameter int unsigned PWR_SETTLE_CYCLES = 20,
    parameter int unsigned COLD_HOLD_CYCLES  = 10
) (
    // clock, reset, bus handshake and deep sleep request
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic        avs_waitrequest_o,
    input wire logic        deep_sleep_i,
    // supply and reset outputs
    input wire logic        power_request_out_o,
    input wire logic        main_power_enable_o,
    input wire logic        pll_enable_o,
    input wire logic        clocks_enable_o,
    input wire logic        periph_reset_o,
    input wire logic        full_core_init_n_o,
    input wire logic        core_reset_n_o,
    input wire logic        bus_owner_o,
    input wire logic        reset_vector_fetch_o,
    // cold load values
    input wire logic        tlb_shutdown_flag_o,
    input wire logic        soft_reset_flag_o,
    input wire logic        error_level_flag_o,
    input wire logic        bootstrap_vector_flag_o,
    input wire logic [4:0]  random_index_o,
    input wire logic [4:0]  wired_index_o,
    input wire logic [31:0] config_init_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // length of the cold hold, counted while clocks run and the core is held
    logic [31:0] cold_cnt;
    logic [31:0] next_cold_cnt;
    always_comb begin
        next_cold_cnt = 32'h0;
        if (!srst_i && clocks_enable_o && !full_core_init_n_o) begin
            next_cold_cnt = cold_cnt + 32'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        cold_cnt <= next_cold_cnt;
    end
    chk_cold_flags: assert property ($rose(full_core_init_n_o) |->
        !tlb_shutdown_flag_o && !soft_reset_flag_o && error_level_flag_o
        && bootstrap_vector_flag_o && random_index_o == 5'h1F && wired_index_o == 5'h00)
        else $error("cold flag values wrong at release");
    chk_cold_config: assert property ($rose(full_core_init_n_o) |->
        config_init_o[31:28] == 4'h0 && config_init_o[22:3] == 20'h04800)
        else $error("cold configuration value wrong at release");
    chk_cold_hold: assert property ($rose(full_core_init_n_o) |-> clocks_enable_o
        && cold_cnt + 32'h1 >= COLD_HOLD_CYCLES && cold_cnt <= COLD_HOLD_CYCLES + 1)
        else $error("cold reset hold length wrong");
    chk_gen_release: assert property ($rose(core_reset_n_o) |-> $past(full_core_init_n_o)
        && reset_vector_fetch_o && bus_owner_o ##1 !reset_vector_fetch_o)
        else $error("general release not after cold release with one fetch pulse");
    chk_pll_settle: assert property ($rose(clocks_enable_o) |->
        $past(pll_enable_o, PLL_SETTLE_CYCLES - 1) && !full_core_init_n_o)
        else $error("clocks started before pll settle time");
    chk_power_settle: assert property ($rose(pll_enable_o) |-> main_power_enable_o
        && $past(main_power_enable_o, PWR_SETTLE_CYCLES - 1) && !power_request_out_o)
        else $error("pll started before supply settle time");
    chk_sleep_off: assert property (deep_sleep_i && !periph_reset_o |=>
        !main_power_enable_o && !core_reset_n_o)
        else $error("deep sleep did not drop main power and reset");
    chk_reset_scope: assert property (!core_reset_n_o |-> periph_reset_o && !bus_owner_o)
        else $error("peripherals or bus free while core held");
    chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
        !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not exactly one cycle");
endmodule
bind rasq_sequencer rasq_props #(.PLL_SETTLE_CYCLES(PLL_SETTLE_CYCLES),
    .PWR_SETTLE_CYCLES(PWR_SETTLE_CYCLES), .COLD_HOLD_CYCLES(COLD_HOLD_CYCLES)) u_rasq_props (.*);

/* verif/rasq_supply_model.sv */
// battery monitor model answering the sequencer's power request
`timescale 1ns/1ps
module rasq_supply_model (
    // bench control and clock
    input  wire logic clk_i,
    input  wire logic batt_ok_i,
    // sequencer side
    input  wire logic power_request_out_i,
    output logic      battery_inhibit_in_o
);
    // a verdict is shown only while a request is pending; otherwise the line
    // wanders, so a sample taken at the wrong time is not read as valid
    initial battery_inhibit_in_o = 1'b0;
    always @(posedge clk_i) begin
        battery_inhibit_in_o <= power_request_out_i ? batt_ok_i : !battery_inhibit_in_o;
    end
endmodule

/* verif/tb_rasq_sequencer.sv */
// self-checking bench for the reset and activation sequencer
`timescale 1ns/1ps
module tb_rasq_sequencer import rasq_pkg::*; ;
    logic clk_i = 1'b0, srst_i = 1'b1, rtc_clk_i = 1'b0, batt_ok = 1'b1;
    logic avs_read_i = 1'b0, avs_write_i = 1'b0, avs_waitrequest_o;
    logic [4:0] avs_address_i = 5'h00;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q, d;
    logic clock_calendar_reset_n_i = 1'b0, reset_switch_n_i = 1'b1, power_button_i = 1'b0;
    logic carrier_detect_n_i = 1'b1, elapsed_alarm_i = 1'b0, card_irq_i = 1'b0;
    logic wakeup_alarm_timer_i = 1'b0, wake_irq_i = 1'b0, battery_inhibit_in_i;
    logic battery_low_i = 1'b0, battery_lock_release_i = 1'b0, deep_sleep_i = 1'b0;
    logic [15:0] gpio_wake_i = 16'h0000;
    logic power_request_out_o, main_power_enable_o, pll_enable_o, clocks_enable_o;
    logic dram_self_refresh_o, periph_reset_o, full_core_init_n_o, core_reset_n_o;
    logic bus_owner_o, reset_vector_fetch_o, tlb_shutdown_flag_o, soft_reset_flag_o;
    logic error_level_flag_o, bootstrap_vector_flag_o;
    logic [4:0] random_index_o, wired_index_o;
    logic [31:0] config_init_o, lfsr = 32'h00015CA2;
    int n_fail = 0, tests_run = 0, rtc_n = 0, rtc_div = 0;

    rasq_sequencer #(.PLL_SETTLE_CYCLES(20), .PWR_SETTLE_CYCLES(20), .COLD_HOLD_CYCLES(10),
        .HALT_LIMIT_TICKS(10)) u_rasq_sequencer (.*);
    rasq_supply_model u_rasq_supply_model (.clk_i(clk_i), .batt_ok_i(batt_ok),
        .power_request_out_i(power_request_out_o), .battery_inhibit_in_o(battery_inhibit_in_i));

    always #2.5 clk_i = ~clk_i;
    // slow tick scaled to 40 core cycles so a whole run stays short
    always @(posedge clk_i) begin
        rtc_div <= (rtc_div == 19) ? 0 : rtc_div + 1;
        if (rtc_div == 19) begin
            rtc_clk_i <= !rtc_clk_i;
            rtc_n <= rtc_n + (rtc_clk_i ? 0 : 1);
        end
    end

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic sig(input int s);
        case (s)
            0: return power_request_out_o;
            1: return core_reset_n_o;
            default: return main_power_enable_o;
        endcase
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_lvl(input int s, input logic v);
        int n;
        n = 0;
        while (sig(s) !== v && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        chk(n < 5000, 1'b1);
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic st(input logic [3:0] s, input logic [2:0] c);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk({q[14:12], q[3:0]}, {c, s});
    endtask
    // one activation handshake, timed in slow ticks
    task automatic act(input logic ok);
        int r;
        batt_ok <= ok;
        wait_lvl(0, 1'b1);
        r = rtc_n;
        power_button_i <= 1'b0;
        carrier_detect_n_i <= 1'b1;
        gpio_wake_i <= 16'h0000;
        wake_irq_i <= 1'b0;
        if (ok) begin
            wait_lvl(2, 1'b1);
            chk(rtc_n - r, 3);
            r = rtc_n;
            wait_lvl(0, 1'b0);
            chk(rtc_n - r, 3);
            wait_lvl(1, 1'b1);
        end else begin
            wait_lvl(0, 1'b0);
            chk(rtc_n - r, 4);
            chk(main_power_enable_o, 1'b0);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        clock_calendar_reset_n_i <= 1'b1;
        act(1'b1);
        chk(config_init_o, {4'h0, 5'h00, 20'h04800, 3'h0});
        st(4'h9, 3'h0);
        bus(1'b0, OFS_WDT_LIMIT, 32'h0);
        chk(q, 32'h00008000);
        d = rnd();
        bus(1'b1, OFS_WDT_LIMIT, d);
        bus(1'b0, OFS_WDT_LIMIT, 32'h0);
        chk(q, {8'h00, d[23:0]});
        bus(1'b0, 5'h10, 32'h0);
        chk(q, 32'h0);
        wait_lvl(1, 1'b0);
        chk(main_power_enable_o, 1'b0);
        st(4'h1, 3'h4);
        carrier_detect_n_i <= 1'b0;
        d = rnd();
        gpio_wake_i <= d[15:0] | 16'h0001;
        repeat (200) @(posedge clk_i);
        chk(power_request_out_o, 1'b0);
        power_button_i <= 1'b1;
        act(1'b0);
        power_button_i <= 1'b1;
        act(1'b1);
        bus(1'b1, OFS_WDT_LIMIT, 32'h4);
        bus(1'b1, OFS_CTRL, 32'h3);
        repeat (8) bus(1'b1, OFS_WDT_CLEAR, rnd());
        repeat (8) bus(1'b1, OFS_WDT_CLEAR, rnd());
        chk(core_reset_n_o, 1'b1);
        wait_lvl(1, 1'b0);
        chk({dram_self_refresh_o, main_power_enable_o}, 2'b01);
        wait_lvl(1, 1'b1);
        st(4'h9, 3'h2);
        bus(1'b1, OFS_CTRL, 32'h6);
        reset_switch_n_i <= 1'b0;
        repeat (30) @(posedge clk_i);
        chk({dram_self_refresh_o, main_power_enable_o, pll_enable_o, core_reset_n_o}, 4'hC);
        reset_switch_n_i <= 1'b1;
        wait_lvl(1, 1'b1);
        st(4'h9, 3'h1);
        deep_sleep_i <= 1'b1;
        @(posedge clk_i);
        deep_sleep_i <= 1'b0;
        gpio_wake_i <= 16'h8000;
        repeat (200) @(posedge clk_i);
        chk(power_request_out_o, 1'b0);
        chk(dram_self_refresh_o, 1'b0);
        wake_irq_i <= 1'b1;
        act(1'b1);
        st(4'h9, 3'h3);
        battery_low_i <= 1'b1;
        wait_lvl(2, 1'b0);
        battery_low_i <= 1'b0;
        repeat (100) @(posedge clk_i);
        d = rnd();
        gpio_wake_i <= 16'h0001 << d[3:0];
        act(1'b1);
        st(4'h9, 3'h5);
        end_of_test();
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        n_fail++;
        end_of_test();
    end
endmodule
